// [design/scs_consts.svh]
`ifndef SCS_CONSTS_SVH
`define SCS_CONSTS_SVH

// Register bus geometry and register offsets.
`define SCS_ADDR_W            8
`define SCS_OFS_CLOCK_DIVISOR 8'h00
`define SCS_OFS_PLL_FEEDBACK  8'h04
`define SCS_OFS_AUX_REF       8'h08
`define SCS_OFS_STATUS        8'h0C
`define SCS_WORD_MASK         8'hFC
`define SCS_MAP_MASK          8'hF0
`define SCS_RESP_OKAY         2'h0
`define SCS_RESP_SLVERR       2'h2

// Reset values and write masks.
`define SCS_RST_CLOCK_DIVISOR 16'h3040
`define SCS_WMASK_CLOCK_DIV   16'h7FDF
`define SCS_RST_PLL_FEEDBACK  9'h030
`define SCS_RST_AUX_REF       8'h00
`define SCS_RST_OSC_SEL       3'h7

// Clock divisor register fields.
`define SCS_DOZE_HI           14
`define SCS_DOZE_LO           12
`define SCS_DOZE_EN           11
`define SCS_FRCPOST_HI        10
`define SCS_FRCPOST_LO        8
`define SCS_POST_HI           7
`define SCS_POST_LO           6
`define SCS_PRE_HI            4
`define SCS_PRE_LO            0

// Auxiliary and reference control register fields.
`define SCS_AUX_SRC           0
`define SCS_AUX_PLL_EN        1
`define SCS_REF_EN            2
`define SCS_REF_SRC           3
`define SCS_REF_EXP_HI        7
`define SCS_REF_EXP_LO        4

// Initial oscillator select codes.
`define SCS_SEL_FAST_RC       3'h0
`define SCS_SEL_FAST_RC_PLL   3'h1
`define SCS_SEL_PRIMARY       3'h2
`define SCS_SEL_PRIMARY_PLL   3'h3
`define SCS_SEL_RESERVED      3'h4
`define SCS_SEL_LOW_POWER_RC  3'h5
`define SCS_SEL_FAST_RC_DIV16 3'h6
`define SCS_SEL_FAST_RC_DIVN  3'h7

// Primary oscillator mode codes.
`define SCS_MODE_EXT_CLOCK    2'h0
`define SCS_MODE_CRYSTAL      2'h1
`define SCS_MODE_HS_CRYSTAL   2'h2

// Divider and multiplier constants.
`define SCS_DIV_W             16
`define SCS_DIV_ONE           16'h0001
`define SCS_FOSC_DIV          16'h0002
`define SCS_DIV16             16'h0010
`define SCS_DIV256            16'h0100
`define SCS_FRCPOST_MAXCODE   3'h7
`define SCS_PRE_OFFSET        6'h02
`define SCS_FB_OFFSET         10'h002
`define SCS_POST_CODE_DIV2    2'h0
`define SCS_POST_CODE_DIV4    2'h1
`define SCS_POST_CODE_DIV8    2'h3
`define SCS_N2_2              4'h2
`define SCS_N2_4              4'h4
`define SCS_N2_8              4'h8
`define SCS_ACC_W             12
`define SCS_ACC_MAX           12'hFFF
`define SCS_MULT_W            10
`define SCS_RDIV_W            9
`define SCS_AUX_MULT          10'h010
`define SCS_AUX_DIV           9'h001

`endif

// [design/scs_pkg.sv]
`include "scs_consts.svh"

package scs_pkg;

  // State of a programmable tick divider.
  typedef struct packed {
    logic [`SCS_DIV_W-1:0] cnt;
    logic                  tick;
  } scs_div_state_t;

  // State of a rate multiplier (phase accumulator).
  typedef struct packed {
    logic [`SCS_ACC_W-1:0] acc;
    logic                  tick;
  } scs_mult_state_t;

  // Whole state of the clock select block.
  typedef struct packed {
    logic [2:0]            oscSel;
    logic [1:0]            priMode;
    logic                  pinTwoFunc;
    logic                  cfgLoaded;
    logic [15:0]           clock_divisor_reg;
    logic [8:0]            fbDiv;
    logic [7:0]            auxRef;
    logic                  awHeld;
    logic [`SCS_ADDR_W-1:0] awAddr;
    logic                  wHeld;
    logic [31:0]           wData;
    logic [3:0]            wStrb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    logic                  oscTick;
    logic                  auxTick;
    logic                  lowPowerRef;
    logic                  refPin;
    logic                  pinTwoOut;
    logic                  pinTwoOe;
  } scs_state_t;

endpackage

// [design/scs_tick_div.sv]
`timescale 1ns/1ps
`include "scs_consts.svh"

// Divides a stream of one-cycle ticks by a programmable integer.
module scs_tick_div (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  tickIn,
  input  wire logic [`SCS_DIV_W-1:0] divisor,
  output logic                       tickOut
);

  scs_pkg::scs_div_state_t s_r;  // Registered state.
  scs_pkg::scs_div_state_t s_nxt;  // Next state.

  // A divisor of zero behaves as one, so a bad setting never stalls the clock.
  always_comb begin
    s_nxt      = s_r;
    s_nxt.tick = 1'b0;
    if (tickIn) begin
      if ((s_r.cnt + `SCS_DIV_ONE) >= divisor) begin
        s_nxt.cnt  = '0;
        s_nxt.tick = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt + `SCS_DIV_ONE;
      end
    end
  end

  // Register the state.
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tickOut = s_r.tick;

endmodule

// [design/scs_rate_mult.sv]
`timescale 1ns/1ps
`include "scs_consts.svh"

// Phase accumulator: ticks at tickIn rate times mult over div.
// The output can carry at most one tick per clock; surplus credit saturates.
module scs_rate_mult (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   tickIn,
  input  wire logic [`SCS_MULT_W-1:0] mult,
  input  wire logic [`SCS_RDIV_W-1:0] div,
  output logic                        tickOut
);

  scs_pkg::scs_mult_state_t s_r;  // Registered state.
  scs_pkg::scs_mult_state_t s_nxt;  // Next state.
  logic [`SCS_ACC_W:0]      sum;  // Accumulator with headroom.

  // Add mult per input tick, spend div per output tick.
  always_comb begin
    sum        = {1'b0, s_r.acc} + (tickIn ? {{(`SCS_ACC_W + 1 - `SCS_MULT_W){1'b0}}, mult} : '0);
    s_nxt      = s_r;
    s_nxt.tick = 1'b0;
    if (sum >= {{(`SCS_ACC_W + 1 - `SCS_RDIV_W){1'b0}}, div}) begin
      sum        = sum - {{(`SCS_ACC_W + 1 - `SCS_RDIV_W){1'b0}}, div};
      s_nxt.tick = 1'b1;
    end
    // Saturation loses phase but never wraps to a false low rate.
    if (sum > {1'b0, `SCS_ACC_MAX}) begin
      sum = {1'b0, `SCS_ACC_MAX};
    end
    s_nxt.acc = sum[`SCS_ACC_W-1:0];
  end

  // Register the state.
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tickOut = s_r.tick;

endmodule

// [design/scs_clock_select.sv]
// Function
// (RQ1) Power-on source taken from two configuration fields
// (RQ2) Decode the eight initial oscillator select codes
// (RQ3) Primary mode picks fast, normal crystal or external
// (RQ4) Erased device starts in fast RC divide-by-N
// (RQ5) Instruction and peripheral clocks are oscillator halved
// (RQ6) Peripheral equals instruction clock unless doze ratio
// (RQ7) Fast RC postscaler divides up to 256
// (RQ8) PLL input prescaled by 2 through 33
// (RQ9) VCO input multiplied by feedback factor M
// (RQ10) VCO output divided by 2, 4 or 8
// (RQ11) PLL output equals input times M over N1*N2
// (RQ12) Software keeps VCO input 0.8 to 8 MHz
// (RQ13) Software keeps VCO output 100 to 200 MHz
// (RQ14) Software keeps PLL output 12.5 to 80 MHz
// (RQ15) Low-power RC clock also feeds watchdog reference
// (RQ16) Auxiliary clock is primary or fast RC times 16
// (RQ17) Software sets auxiliary clock to 120 MHz
// (RQ18) Fine PWM resolution only from the auxiliary PLL
// (RQ19) Primary PLL feeding auxiliary stays at 30 MIPS
// (RQ20) Reference output from system or crystal, scaled
// (RQ21) Pin two function set by configuration bit
// (RQ22) Postscale codes 00, 01, 11 give 2, 4, 8
// (RQ23) Prescale code plus two gives N1
// (RQ24) Feedback code plus two gives M
// (RQ25) Software never programs the reserved select code
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
`include "scs_consts.svh"

module scs_clock_select (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic [2:0]             initialOscSel,
  input  wire logic [1:0]             primaryOscMode,
  input  wire logic                   oscPinTwoFuncCfg,
  input  wire logic                   fastRcTick,
  input  wire logic                   crystalTick,
  input  wire logic                   extClockTick,
  input  wire logic                   lowPowerRcTick,
  input  wire logic [`SCS_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`SCS_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output logic                        oscTick,
  output logic                        periphTick,
  output logic                        cpuTick,
  output logic                        lowPowerRefTick,
  output logic                        auxTick,
  output logic                        pwmFineRes,
  output logic                        refClkOut,
  output logic                        refClkOe,
  output logic                        oscPinTwoOut,
  output logic                        oscPinTwoOe
);

  scs_pkg::scs_state_t      s_r;  // Registered state of the whole block.
  scs_pkg::scs_state_t      s_nxt;  // Next state.
  logic [31:0]              wrWord;  // Register word after byte-lane merge.
  logic                     primaryTick;  // Primary oscillator tick for the chosen mode.
  logic                     pllInTick;  // Tick entering the main PLL.
  logic                     pllTick;  // Main PLL output tick.
  logic                     auxPllTick;  // Auxiliary PLL output tick.
  logic                     fastRcPostTick;  // Fast RC after its postscaler.
  logic                     refTick;  // Scaled reference tick.
  logic [`SCS_DIV_W-1:0]    fastRcDivisor;  // Fast RC postscale ratio.
  logic [`SCS_DIV_W-1:0]    dozeDivisor;  // Processor-to-peripheral ratio.
  logic [`SCS_DIV_W-1:0]    refDivisor;  // Reference output ratio.
  logic [5:0]               preDiv;  // Prescale factor N1.
  logic [3:0]               postDiv;  // Postscale factor N2.
  logic [`SCS_MULT_W-1:0]   fbMult;  // Feedback factor M.
  logic [`SCS_RDIV_W-1:0]   pllDiv;  // Product N1*N2.
  logic                     pllActive;  // A PLL mode is selected.
  logic                     crystalOnPins;  // Crystal occupies pin two.

  // True when the address falls inside the register window.
  function automatic logic isMapped(input logic [`SCS_ADDR_W-1:0] a);
    isMapped = ~|(a & `SCS_MAP_MASK);
  endfunction

  // Word-aligned form of a byte address; the low two bits are ignored.
  function automatic logic [`SCS_ADDR_W-1:0] wordOf(input logic [`SCS_ADDR_W-1:0] a);
    wordOf = a & `SCS_WORD_MASK;
  endfunction

  // Postscale code to N2; the reserved code falls back to divide-by-4.
  function automatic logic [3:0] decodePost(input logic [1:0] code);
    case (code)
      `SCS_POST_CODE_DIV2: decodePost = `SCS_N2_2;  // RQ22
      `SCS_POST_CODE_DIV8: decodePost = `SCS_N2_8;  // RQ22
      default:             decodePost = `SCS_N2_4;  // RQ22
    endcase
  endfunction

  // Merge the written bytes into an old register word.
  function automatic logic [31:0] mergeWord(input logic [31:0] old, input logic [31:0] data,
                                            input logic [3:0] strb);
    mergeWord = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        mergeWord[i*8 +: 8] = data[i*8 +: 8];
      end
    end
  endfunction

  // Read view of a register; unmapped and unused bits read as zero.
  function automatic logic [31:0] readWord(input scs_pkg::scs_state_t st,
                                           input logic [`SCS_ADDR_W-1:0] a, input logic pll,
                                           input logic fine);
    readWord = '0;
    if (isMapped(a)) begin
      case (wordOf(a))
        `SCS_OFS_CLOCK_DIVISOR: readWord = {16'h0000, st.clock_divisor_reg};
        `SCS_OFS_PLL_FEEDBACK:  readWord = {23'h0, st.fbDiv};
        `SCS_OFS_AUX_REF:       readWord = {24'h0, st.auxRef};
        `SCS_OFS_STATUS:        readWord = {23'h0, st.cfgLoaded, fine, pll, st.pinTwoFunc,
                                            st.priMode, st.oscSel};
        default:                readWord = '0;
      endcase
    end
  endfunction

  // Divider settings from the software registers.
  always_comb begin
    preDiv  = s_r.clock_divisor_reg[`SCS_PRE_HI:`SCS_PRE_LO] + `SCS_PRE_OFFSET;  // RQ8 RQ23
    postDiv = decodePost(s_r.clock_divisor_reg[`SCS_POST_HI:`SCS_POST_LO]);  // RQ10
    fbMult  = {1'b0, s_r.fbDiv} + `SCS_FB_OFFSET;  // RQ9 RQ24
    pllDiv  = `SCS_RDIV_W'(preDiv * postDiv);  // RQ11
    // Divide-by-16 mode ignores the postscale field.
    if (s_r.oscSel == `SCS_SEL_FAST_RC_DIV16) begin
      fastRcDivisor = `SCS_DIV16;  // RQ2
    end else if (s_r.clock_divisor_reg[`SCS_FRCPOST_HI:`SCS_FRCPOST_LO] == `SCS_FRCPOST_MAXCODE) begin
      fastRcDivisor = `SCS_DIV256;  // RQ7
    end else begin
      fastRcDivisor = `SCS_DIV_ONE << s_r.clock_divisor_reg[`SCS_FRCPOST_HI:`SCS_FRCPOST_LO];  // RQ7
    end
    // Only enabled doze slows the processor below the peripherals.
    dozeDivisor = s_r.clock_divisor_reg[`SCS_DOZE_EN] ? (`SCS_DIV_ONE << s_r.clock_divisor_reg[`SCS_DOZE_HI:`SCS_DOZE_LO])
                                           : `SCS_DIV_ONE;  // RQ6
    refDivisor  = `SCS_DIV_ONE << s_r.auxRef[`SCS_REF_EXP_HI:`SCS_REF_EXP_LO];  // RQ20
  end

  // Source routing decided by the captured configuration.
  always_comb begin
    case (s_r.priMode)
      `SCS_MODE_HS_CRYSTAL: primaryTick = crystalTick;  // RQ3
      `SCS_MODE_CRYSTAL:    primaryTick = crystalTick;  // RQ3
      `SCS_MODE_EXT_CLOCK:  primaryTick = extClockTick;  // RQ3
      default:              primaryTick = 1'b0;
    endcase
    pllActive     = (s_r.oscSel == `SCS_SEL_PRIMARY_PLL) || (s_r.oscSel == `SCS_SEL_FAST_RC_PLL);
    pllInTick     = (s_r.oscSel == `SCS_SEL_PRIMARY_PLL) ? primaryTick : fastRcTick;
    crystalOnPins = ((s_r.oscSel == `SCS_SEL_PRIMARY) || (s_r.oscSel == `SCS_SEL_PRIMARY_PLL))
                    && (s_r.priMode != `SCS_MODE_EXT_CLOCK);
  end

  // Fast RC postscaler, used by both divided fast RC modes.
  scs_tick_div u_fast_rc_post (
    .clk     (clk),
    .rst     (rst),
    .tickIn  (fastRcTick),
    .divisor (fastRcDivisor),
    .tickOut (fastRcPostTick)
  );

  // Main PLL: input times M over N1*N2.
  scs_rate_mult u_main_pll (
    .clk     (clk),
    .rst     (rst),
    .tickIn  (pllInTick),
    .mult    (fbMult),
    .div     (pllDiv),
    .tickOut (pllTick)
  );

  // Auxiliary PLL with its fixed sixteen-times factor.
  scs_rate_mult u_aux_pll (
    .clk     (clk),
    .rst     (rst),
    .tickIn  (s_r.auxRef[`SCS_AUX_SRC] ? fastRcTick : primaryTick),
    .mult    (`SCS_AUX_MULT),
    .div     (`SCS_AUX_DIV),
    .tickOut (auxPllTick)
  );

  // Peripheral time base is the oscillator halved.  RQ5
  scs_tick_div u_periph_div (
    .clk     (clk),
    .rst     (rst),
    .tickIn  (s_r.oscTick),
    .divisor (`SCS_FOSC_DIV),  // RQ5
    .tickOut (periphTick)
  );

  // Instruction clock is the peripheral clock, slowed only in doze.
  scs_tick_div u_doze_div (
    .clk     (clk),
    .rst     (rst),
    .tickIn  (periphTick),
    .divisor (dozeDivisor),
    .tickOut (cpuTick)
  );

  // Reference output scaler.
  scs_tick_div u_ref_div (
    .clk     (clk),
    .rst     (rst),
    .tickIn  (s_r.auxRef[`SCS_REF_SRC] ? crystalTick : s_r.oscTick),
    .divisor (refDivisor),
    .tickOut (refTick)
  );

  // Bus slave handshakes; a pending response blocks new writes.
  assign s_axi_awready = !s_r.awHeld && !s_r.bvalid;
  assign s_axi_wready  = !s_r.wHeld && !s_r.bvalid;
  assign s_axi_arready = !s_r.rvalid;

  // Next state of the block.
  always_comb begin
    s_nxt  = s_r;
    wrWord = '0;
    // Configuration is caught once, after reset release.
    if (!s_r.cfgLoaded) begin
      s_nxt.oscSel     = initialOscSel;  // RQ1
      s_nxt.priMode    = primaryOscMode;  // RQ1
      s_nxt.pinTwoFunc = oscPinTwoFuncCfg;  // RQ21
      s_nxt.cfgLoaded  = 1'b1;
    end
    // Oscillator selection; the reserved code runs from fast RC.
    case (s_r.oscSel)
      `SCS_SEL_FAST_RC:       s_nxt.oscTick = fastRcTick;  // RQ2
      `SCS_SEL_FAST_RC_PLL:   s_nxt.oscTick = pllTick;  // RQ2 RQ11
      `SCS_SEL_PRIMARY:       s_nxt.oscTick = primaryTick;  // RQ2
      `SCS_SEL_PRIMARY_PLL:   s_nxt.oscTick = pllTick;  // RQ2 RQ11
      `SCS_SEL_LOW_POWER_RC:  s_nxt.oscTick = lowPowerRcTick;  // RQ2
      `SCS_SEL_FAST_RC_DIV16: s_nxt.oscTick = fastRcPostTick;  // RQ2
      `SCS_SEL_FAST_RC_DIVN:  s_nxt.oscTick = fastRcPostTick;  // RQ2 RQ7
      default:                s_nxt.oscTick = fastRcTick;
    endcase
    s_nxt.lowPowerRef = lowPowerRcTick;  // RQ15
    // Without the auxiliary PLL the system oscillator stands in, at coarse resolution.
    s_nxt.auxTick     = s_r.auxRef[`SCS_AUX_PLL_EN] ? auxPllTick : s_r.oscTick;  // RQ16 RQ18
    // Reference pin toggles per scaled tick and idles low when disabled.
    s_nxt.refPin      = s_r.auxRef[`SCS_REF_EN] && (s_r.refPin ^ refTick);  // RQ20
    // Pin two carries the instruction clock when free.
    s_nxt.pinTwoOe    = !crystalOnPins && !s_r.pinTwoFunc;  // RQ21
    s_nxt.pinTwoOut   = s_nxt.pinTwoOe && (s_r.pinTwoOut ^ cpuTick);  // RQ21
    // Capture write address and data in either order.
    if (s_axi_awvalid && s_axi_awready) begin
      s_nxt.awHeld = 1'b1;
      s_nxt.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_nxt.wHeld = 1'b1;
      s_nxt.wData = s_axi_wdata;
      s_nxt.wStrb = s_axi_wstrb;
    end
    // Retire the write response.
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    // Perform the write once both halves are held.
    if (s_nxt.awHeld && s_nxt.wHeld && !s_r.bvalid) begin
      wrWord       = mergeWord(readWord(s_r, s_nxt.awAddr, pllActive, s_r.auxRef[`SCS_AUX_PLL_EN]),
                               s_nxt.wData, s_nxt.wStrb);
      s_nxt.awHeld = 1'b0;
      s_nxt.wHeld  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = isMapped(s_nxt.awAddr) ? `SCS_RESP_OKAY : `SCS_RESP_SLVERR;
      if (isMapped(s_nxt.awAddr)) begin
        case (wordOf(s_nxt.awAddr))
          `SCS_OFS_CLOCK_DIVISOR: s_nxt.clock_divisor_reg = wrWord[15:0] & `SCS_WMASK_CLOCK_DIV;
          `SCS_OFS_PLL_FEEDBACK:  s_nxt.fbDiv = wrWord[8:0];
          `SCS_OFS_AUX_REF:       s_nxt.auxRef = wrWord[7:0];
          default:                s_nxt.clock_divisor_reg = s_r.clock_divisor_reg;
        endcase
      end
    end
    // Retire the read response, then accept a new read.
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = readWord(s_r, s_axi_araddr, pllActive, s_r.auxRef[`SCS_AUX_PLL_EN]);
      s_nxt.rresp  = isMapped(s_axi_araddr) ? `SCS_RESP_OKAY : `SCS_RESP_SLVERR;
    end
  end

  // Register the state; reset selects the erased default.
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r        <= '0;
      s_r.oscSel <= `SCS_RST_OSC_SEL;  // RQ4
      s_r.clock_divisor_reg <= `SCS_RST_CLOCK_DIVISOR;  // RQ22
      s_r.fbDiv  <= `SCS_RST_PLL_FEEDBACK;
      s_r.auxRef <= `SCS_RST_AUX_REF;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from flip-flops.
  assign s_axi_bvalid    = s_r.bvalid;
  assign s_axi_bresp     = s_r.bresp;
  assign s_axi_rvalid    = s_r.rvalid;
  assign s_axi_rdata     = s_r.rdata;
  assign s_axi_rresp     = s_r.rresp;
  assign oscTick         = s_r.oscTick;
  assign lowPowerRefTick = s_r.lowPowerRef;
  assign auxTick         = s_r.auxTick;
  assign pwmFineRes      = s_r.auxRef[`SCS_AUX_PLL_EN];  // RQ18
  assign refClkOut       = s_r.refPin;
  assign refClkOe        = s_r.auxRef[`SCS_REF_EN];
  assign oscPinTwoOut    = s_r.pinTwoOut;
  assign oscPinTwoOe     = s_r.pinTwoOe;

endmodule

// [verification/scs_clock_select_monitor.sv]
`timescale 1ns/1ps
`include "scs_consts.svh"

// Watches pulse outputs and the read channel.
module scs_clock_select_monitor (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [2:0]  initialOscSel,
  input wire logic        fastRcTick,
  input wire logic        lowPowerRcTick,
  input wire logic        oscTick,
  input wire logic        periphTick,
  input wire logic        cpuTick,
  input wire logic        lowPowerRefTick,
  input wire logic        refClkOut,
  input wire logic        refClkOe,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Read address taken.
  sequence arTaken; s_axi_arvalid && s_axi_arready; endsequence
  // Error answer, zero data.
  sequence rdErr; s_axi_rvalid && s_axi_rresp == `SCS_RESP_SLVERR && s_axi_rdata == 32'h0; endsequence
  AST_LOW_POWER_RC_OSC_REF: assert property (lowPowerRcTick |=> lowPowerRefTick)
    else $error("lp ref pulse missing");
  AST_PERIPH_HALF: assert property (periphTick |-> $past(oscTick))
    else $error("periph pulse unexplained");
  AST_CPU_AFTER: assert property (cpuTick |-> $past(periphTick))
    else $error("cpu pulse unexplained");
  AST_FRC_DIRECT: assert property ((initialOscSel == `SCS_SEL_FAST_RC && fastRcTick && !$past(rst)) |=> oscTick)
    else $error("fast RC pulse not passed on");
  AST_REF_OFF: assert property (!refClkOe && $past(!refClkOe) |-> !refClkOut)
    else $error("ref pin moves while off");
  AST_RD_ANSWER: assert property (arTaken |=> s_axi_rvalid)
    else $error("read answer late");
  AST_RD_UNMAPPED: assert property (arTaken ##0 (s_axi_araddr[7:4] != 4'h0) |=> rdErr)
    else $error("unmapped read not refused");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
endmodule

// [verification/scs_clock_select_tb.sv]
`timescale 1ns/1ps
`include "scs_consts.svh"

// Self-checking bench; pulse counts against hand-worked rates.
module scs_clock_select_tb;
  logic        clk, rst, oscPinTwoFuncCfg; // Clock, reset, pin-two bit.
  logic [2:0]  initialOscSel; // Power-on select code.
  logic [1:0]  primaryOscMode, s_axi_bresp, s_axi_rresp;
  logic [3:0]  src, s_axi_wstrb; // Source pulses: fast RC, crystal, external, low-power.
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, oscTick, periphTick, cpuTick;
  logic        lowPowerRefTick, auxTick, pwmFineRes, refClkOut, refClkOe, oscPinTwoOut, oscPinTwoOe;
  int          cnt[4], b[4], num_errors, samples_checked; // Pulse totals and a snapshot of them.
  // Per boot case: select, mode, source, pulses, expected osc pulses.
  int ts[8] = '{0,7,6,5,4,2,2,2};
  int tm[8] = '{0,0,0,0,0,0,1,2};
  int tr[8] = '{0,0,0,3,0,2,1,1};
  int tn[8] = '{16,16,32,8,8,8,8,8};
  int te[8] = '{16,16,2,8,8,8,8,8};

  scs_clock_select i_dut (.*, .fastRcTick(src[0]), .crystalTick(src[1]), .extClockTick(src[2]),
    .lowPowerRcTick(src[3]));

  // Clock at 100 ns period.
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  // Totals only grow, so no clear races an increment.
  always @(posedge clk) begin
    cnt[0] <= cnt[0] + oscTick;
    cnt[1] <= cnt[1] + periphTick;
    cnt[2] <= cnt[2] + cpuTick;
    cnt[3] <= cnt[3] + auxTick;
  end
  task close_out;
    $display("counts: %0d checked, %0d mismatches", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  // A bounded wait that ran out ends the run.
  task hang;
    num_errors++;
    $display("unexpected bus answer: expected one, seen none");
    close_out;
  endtask
  // Write: address and data together, each released when taken.
  task wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 0;
    if (i == 50) hang;
    @(posedge clk);
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid === 1'b1) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
    if (i == 50) hang;
    @(posedge clk);
  endtask
  // Power-on with the configuration held over the capture edge; the second edge lets pin outputs settle.
  task boot(input logic [2:0] s, input logic [1:0] m, input logic c);
    rst <= 1;
    initialOscSel <= s;
    primaryOscMode <= m;
    oscPinTwoFuncCfg <= c;
    repeat (20) @(posedge clk);
    rst <= 0;
    repeat (3) @(posedge clk);
  endtask
  // n pulses on source s, g cycles apart, then a drain.
  task run(input int s, input int n, input int g);
    b = cnt;
    repeat (n) begin
      src[s] <= 1;
      @(posedge clk);
      src[s] <= 0;
      repeat (g - 1) @(posedge clk);
    end
    repeat (40) @(posedge clk);
  endtask
  task t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    boot(0, 0, 0);
    rd(8'h00, d, r); chk("clock divisor", 32'h3040, d);
    rd(8'h04, d, r); chk("feedback", 32'h30, d);
    rd(8'h0C, d, r); chk("status", 32'h100, d);
    rd(8'h10, d, r); chk("unmapped resp", 32'h2, {30'h0, r});
    wr(8'h00, 32'hFFFF);
    rd(8'h00, d, r); chk("divisor mask", 32'h7FDF, d);
    chk("pin two oe", 1, oscPinTwoOe);
    boot(0, 0, 1);
    chk("pin two oe", 0, oscPinTwoOe);
    $display("test regs done");
  endtask
  task t_sel;
    for (int k = 0; k < 8; k++) begin
      boot(ts[k], tm[k], 0);
      run(tr[k], tn[k], 4);
      chk("osc", te[k], cnt[0] - b[0]);
      chk("periph", te[k] / 2, cnt[1] - b[1]);
      chk("cpu", te[k] / 2, cnt[2] - b[2]);
    end
    boot(7, 0, 0);
    wr(8'h00, 32'h0240);
    run(0, 16, 4); chk("frc post", 4, cnt[0] - b[0]);
    $display("test select done");
  endtask
  task t_pll;
    boot(1, 0, 0);
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h6);
    run(0, 16, 4); chk("pll 8/4", 32, cnt[0] - b[0]);
    wr(8'h00, 32'hC1);
    wr(8'h04, 32'h2E);
    run(0, 16, 4); chk("pll 48/24", 32, cnt[0] - b[0]);
    $display("test pll done");
  endtask
  task t_doze;
    boot(0, 0, 0);
    wr(8'h00, 32'h1840);
    run(0, 16, 4); chk("doze cpu", 4, cnt[2] - b[2]);
    wr(8'h08, 32'h7);
    chk("fine res", 1, pwmFineRes);
    chk("ref oe", 1, refClkOe);
    run(0, 4, 20); chk("aux", 64, cnt[3] - b[3]);
    $display("test doze aux done");
  endtask
  initial begin
    rst = 1;
    src = 0;
    {initialOscSel, primaryOscMode, oscPinTwoFuncCfg} = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
    s_axi_wstrb = 4'hF;
    @(posedge clk);
    t_regs;
    t_sel;
    t_pll;
    t_doze;
    close_out;
  end
endmodule

bind scs_clock_select scs_clock_select_monitor i_mon (.*);
